// >>> gateway_buffer_diagnostics.sv
// Functional notes
// - Two diagnostic groups: output error (overflow, loss), input error (overflow, loss, overflow).
// - Output FIFO overflow from controller writes raises output-side overflow diagnostic.
// - Output command byte not previous plus one mod 256 raises output data loss.
// - Input FIFO overflow from serial data raises input-side overflow diagnostic.
// - Serial byte not taken in time is lost; raises input data loss.
// - Serial frames over 506 bytes raise input-side data overflow diagnostic.
`timescale 1ns/10ps
module gateway_buffer_diagnostics #(
	parameter int DATA_W = gw_diag_pkg::DATA_W,
	parameter int OUT_DEPTH = gw_diag_pkg::FIFO_DEPTH,
	parameter int IN_DEPTH = gw_diag_pkg::FIFO_DEPTH,
	parameter int MAX_FRAME = gw_diag_pkg::MAX_FRAME_BYTES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Controller output data
	input wire logic ctl_out_valid,
	input wire logic [DATA_W-1:0] ctl_out_data,
	input wire logic ctl_out_first,
	output logic ctl_out_ready,
	// Serial transmit side
	output logic [DATA_W-1:0] ser_tx_data,
	output logic ser_tx_valid,
	input wire logic ser_tx_ready,
	// Serial receive side
	input wire logic ser_rx_valid,
	input wire logic [DATA_W-1:0] ser_rx_data,
	input wire logic ser_rx_frame_end,
	input wire logic ser_rx_lost,
	// Controller input data
	output logic [DATA_W-1:0] ctl_in_data,
	output logic ctl_in_valid,
	input wire logic ctl_in_ready,
	// Diagnostic report
	output gw_diag_pkg::diag_t diag,
	output logic diag_valid,
	output logic out_data_error,
	output logic in_data_error,
	input wire logic diag_ack
);
	import gw_diag_pkg::*;

	// ----------------------------------------
	// Output path
	// ----------------------------------------
	logic out_fifo_ready;
	logic out_overflow_ev;
	logic seq_gap;

	// Ready is exported; a write while full is dropped and reported
	assign ctl_out_ready = out_fifo_ready;
	assign out_overflow_ev = ctl_out_valid && !out_fifo_ready;

	gw_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(OUT_DEPTH)
	) out_fifo (
		.clk(clk),
		.reset(reset),
		.in_data(ctl_out_data),
		.in_valid(ctl_out_valid),
		.in_ready(out_fifo_ready),
		.out_data(ser_tx_data),
		.out_valid(ser_tx_valid),
		.out_ready(ser_tx_ready)
	);

	// Relies on the controller stepping the byte by one
	gw_seq_check seq_check (
		.clk(clk),
		.reset(reset),
		.cmd_valid(ctl_out_valid && ctl_out_first && out_fifo_ready),
		.cmd_byte(ctl_out_data[7:0]),
		.gap(seq_gap)
	);

	// ----------------------------------------
	// Input path
	// ----------------------------------------
	logic rx_valid_s1, rx_valid_s2, rx_valid_d;
	logic [DATA_W-1:0] rx_data_s1, rx_data_s2;
	logic end_s1, end_s2, lost_s1, lost_s2;
	logic rx_strobe;
	logic in_fifo_ready;
	logic in_overflow_ev;
	logic frame_over_ev;
	logic [FRAME_CNT_W-1:0] frame_cnt, next_frame_cnt;
	logic frame_over_seen, next_frame_over_seen;

	// Pins from the serial side pass two flops
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_valid_s1 <= 1'b0;
			rx_valid_s2 <= 1'b0;
			rx_valid_d <= 1'b0;
			rx_data_s1 <= '0;
			rx_data_s2 <= '0;
			end_s1 <= 1'b0;
			end_s2 <= 1'b0;
			lost_s1 <= 1'b0;
			lost_s2 <= 1'b0;
		end else begin
			rx_valid_s1 <= ser_rx_valid;
			rx_valid_s2 <= rx_valid_s1;
			rx_valid_d <= rx_valid_s2;
			rx_data_s1 <= ser_rx_data;
			rx_data_s2 <= rx_data_s1;
			end_s1 <= ser_rx_frame_end;
			end_s2 <= end_s1;
			lost_s1 <= ser_rx_lost;
			lost_s2 <= lost_s1;
		end
	end

	// Rising edge of valid marks one received byte; data held stable meanwhile
	assign rx_strobe = rx_valid_s2 && !rx_valid_d;
	// The UART cannot be stalled, so a full FIFO drops the byte
	assign in_overflow_ev = rx_strobe && !in_fifo_ready;

	gw_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(IN_DEPTH)
	) in_fifo (
		.clk(clk),
		.reset(reset),
		.in_data(rx_data_s2),
		.in_valid(rx_strobe),
		.in_ready(in_fifo_ready),
		.out_data(ctl_in_data),
		.out_valid(ctl_in_valid),
		.out_ready(ctl_in_ready)
	);

	// Count bytes per frame; report once per frame past the limit
	always_comb begin
		next_frame_cnt = frame_cnt;
		next_frame_over_seen = frame_over_seen;
		frame_over_ev = 1'b0;
		if (rx_strobe) begin
			if (frame_cnt == FRAME_CNT_W'(MAX_FRAME)) begin
				frame_over_ev = !frame_over_seen;
				next_frame_over_seen = 1'b1;
			end else begin
				next_frame_cnt = frame_cnt + 1'b1;
			end
		end
		if (end_s2) begin
			next_frame_cnt = '0;
			next_frame_over_seen = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			frame_cnt <= '0;
			frame_over_seen <= 1'b0;
		end else begin
			frame_cnt <= next_frame_cnt;
			frame_over_seen <= next_frame_over_seen;
		end
	end

	// ----------------------------------------
	// Pending flags and reporting
	// ----------------------------------------
	diag_t events, pending, next_pending, next_diag;
	report_state_t state, next_state;
	logic next_diag_valid;

	always_comb begin
		events = DIAG_NONE;
		events.out_fifo_overflow = out_overflow_ev;
		events.out_data_loss = seq_gap;
		events.in_fifo_overflow = in_overflow_ev;
		events.in_data_loss = lost_s2;
		events.in_data_overflow = frame_over_ev;
	end

	// Pending is cleared as the snapshot is taken, but new events win over the clear
	always_comb begin
		next_state = state;
		next_pending = pending;
		next_diag = diag;
		next_diag_valid = diag_valid;
		case (state)
			REPORT_IDLE: begin
				if (pending != DIAG_NONE) begin
					next_diag = pending;
					next_diag_valid = 1'b1;
					next_pending = DIAG_NONE;
					next_state = REPORT_SEND;
				end
			end
			REPORT_SEND: begin
				if (diag_ack) begin
					next_diag_valid = 1'b0;
					next_state = REPORT_WAIT;
				end
			end
			REPORT_WAIT: begin
				next_diag = DIAG_NONE;
				next_state = REPORT_IDLE;
			end
			default: begin
				next_state = REPORT_IDLE;
			end
		endcase
		next_pending = next_pending | events;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= REPORT_IDLE;
			pending <= DIAG_NONE;
			diag <= DIAG_NONE;
			diag_valid <= 1'b0;
		end else begin
			state <= next_state;
			pending <= next_pending;
			diag <= next_diag;
			diag_valid <= next_diag_valid;
		end
	end

	// Category summaries for the controller
	assign out_data_error = diag_valid && (diag.out_fifo_overflow || diag.out_data_loss);
	assign in_data_error = diag_valid &&
		(diag.in_fifo_overflow || diag.in_data_loss || diag.in_data_overflow);
endmodule

// >>> gw_diag_pkg.sv
package gw_diag_pkg;

	// ----------------------------------------
	// Sizes and limits
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int MAX_FRAME_BYTES = 506;
	localparam int FRAME_CNT_W = 10;
	localparam logic [7:0] CMD_STEP = 8'h01;
	localparam logic [7:0] CMD_RESET_VAL = 8'h00;

	// ----------------------------------------
	// Diagnostic carrier
	// ----------------------------------------
	typedef struct packed {
		logic out_fifo_overflow;
		logic out_data_loss;
		logic in_fifo_overflow;
		logic in_data_loss;
		logic in_data_overflow;
	} diag_t;

	localparam diag_t DIAG_NONE = '0;

	typedef enum logic [1:0] {
		REPORT_IDLE = 2'b00,
		REPORT_SEND = 2'b01,
		REPORT_WAIT = 2'b11
	} report_state_t;

endpackage

// >>> gw_fifo.sv
`timescale 1ns/10ps
module gw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage needs no reset; empty count masks stale words
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

// >>> gw_seq_check.sv
`timescale 1ns/10ps
module gw_seq_check (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Command byte arrival
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	// Gap detected
	output logic gap
);
	import gw_diag_pkg::*;

	logic [7:0] last_cmd, next_last_cmd;
	logic seen, next_seen;
	logic next_gap;

	// First command after reset only seeds the expectation
	always_comb begin
		next_last_cmd = cmd_valid ? cmd_byte : last_cmd;
		next_seen = seen | cmd_valid;
		next_gap = cmd_valid && seen && (cmd_byte != 8'(last_cmd + CMD_STEP));
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			last_cmd <= CMD_RESET_VAL;
			seen <= 1'b0;
			gap <= 1'b0;
		end else begin
			last_cmd <= next_last_cmd;
			seen <= next_seen;
			gap <= next_gap;
		end
	end
endmodule

// >>> gbd_props.sv
`timescale 1ns/10ps
module gbd_props (
	// Watched ports
	input wire logic clk,
	input wire logic reset,
	input wire logic ctl_out_valid,
	input wire logic ctl_out_ready,
	input wire logic ctl_out_first,
	input wire logic [7:0] ctl_out_data,
	input wire logic ser_rx_lost,
	input wire gw_diag_pkg::diag_t diag,
	input wire logic diag_valid,
	input wire logic diag_ack,
	input wire logic out_data_error,
	input wire logic in_data_error
);
	logic [7:0] last_cmd;
	logic seeded;
	always_ff @(posedge clk) begin
		if (reset) begin
			seeded <= 1'b0;
			last_cmd <= 8'h00;
		end else if (ctl_out_valid && ctl_out_ready && ctl_out_first) begin
			seeded <= 1'b1;
			last_cmd <= ctl_out_data;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_gap;
		ctl_out_valid && ctl_out_ready && ctl_out_first && seeded && ctl_out_data != last_cmd + 8'h01;
	endsequence
	sequence s_free;
		!diag_valid;
	endsequence
	property p_out_err;
		out_data_error == (diag_valid && (diag.out_fifo_overflow || diag.out_data_loss));
	endproperty
	property p_in_err;
		in_data_error == (diag_valid &&
			(diag.in_fifo_overflow || diag.in_data_loss || diag.in_data_overflow));
	endproperty
	property p_gap;
		s_gap ##0 s_free |-> ##[1:4] diag_valid && diag.out_data_loss;
	endproperty
	property p_ovf;
		ctl_out_valid && !ctl_out_ready ##0 s_free |-> ##[1:4] diag_valid && diag.out_fifo_overflow;
	endproperty
	property p_lost;
		$rose(ser_rx_lost) ##0 s_free |-> ##[1:6] diag_valid && diag.in_data_loss;
	endproperty
	property p_hold;
		diag_valid && !diag_ack |=> diag_valid && $stable(diag);
	endproperty
	property p_ack;
		diag_valid && diag_ack |=> !diag_valid;
	endproperty
	a_out_err: assert property (p_out_err) else $error("output flag wrong");
	a_in_err: assert property (p_in_err) else $error("input flag wrong");
	a_gap: assert property (p_gap) else $error("gap not reported");
	a_ovf: assert property (p_ovf) else $error("overflow not reported");
	a_lost: assert property (p_lost) else $error("loss not reported");
	a_hold: assert property (p_hold) else $error("report not held");
	a_ack: assert property (p_ack) else $error("report not released");
endmodule

// >>> gw_ctl_model.sv
`timescale 1ns/10ps
module gw_ctl_model (
	// Clock
	input wire logic clk,
	// Output data and report
	output logic ctl_out_valid,
	output logic [7:0] ctl_out_data,
	output logic ctl_out_first,
	input wire logic ctl_out_ready,
	input wire gw_diag_pkg::diag_t diag,
	input wire logic diag_valid,
	output logic diag_ack
);
	logic [7:0] cmd = 8'hfd;
	initial {ctl_out_valid, ctl_out_first, diag_ack, ctl_out_data} = 11'h000;
	// Skip a value only on request, to provoke a gap
	task automatic send_cmd(input bit skip);
		cmd = cmd + (skip ? 8'h02 : 8'h01);
		{ctl_out_valid, ctl_out_first, ctl_out_data} = {2'h3, cmd};
		while (!ctl_out_ready) @(posedge clk) #1;
		@(posedge clk) #1;
		{ctl_out_valid, ctl_out_first, ctl_out_data} = {2'h0, ~cmd};
		// One idle edge so back-to-back calls never drive valid twice in a step
		@(posedge clk) #1;
	endtask
	// Ignores ready on purpose: meant to overrun
	task automatic flood(input int n);
		for (int i = 0; i < n; i++) begin
			{ctl_out_valid, ctl_out_data} = {1'h1, i[7:0]};
			@(posedge clk) #1;
		end
		ctl_out_valid = 1'b0;
		ctl_out_data = ~ctl_out_data;
	endtask
	task automatic take_diag(output gw_diag_pkg::diag_t d);
		d = '0;
		for (int i = 0; i < 80 && !diag_valid; i++) @(posedge clk) #1;
		d = diag_valid ? diag : '0;
		diag_ack = diag_valid;
		@(posedge clk) #1;
		diag_ack = 1'b0;
	endtask
endmodule

// >>> gateway_buffer_diagnostics_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module gateway_buffer_diagnostics_tb;
	import gw_diag_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ser_tx_ready = 1'b1;
	logic ser_rx_valid = 1'b0;
	logic [7:0] ser_rx_data = 8'h00;
	logic ser_rx_frame_end = 1'b0;
	logic ser_rx_lost = 1'b0;
	logic ctl_in_ready = 1'b1;
	logic ctl_out_valid, ctl_out_first, ctl_out_ready, ser_tx_valid, ctl_in_valid;
	logic diag_valid, out_data_error, in_data_error, diag_ack;
	logic [7:0] ctl_out_data, ser_tx_data, ctl_in_data;
	diag_t diag, d;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	gateway_buffer_diagnostics dut_u (.clk, .reset, .ctl_out_valid, .ctl_out_data, .ctl_out_first,
		.ctl_out_ready, .ser_tx_data, .ser_tx_valid, .ser_tx_ready, .ser_rx_valid, .ser_rx_data,
		.ser_rx_frame_end, .ser_rx_lost, .ctl_in_data, .ctl_in_valid, .ctl_in_ready, .diag,
		.diag_valid, .out_data_error, .in_data_error, .diag_ack);
	gw_ctl_model ctl_u (.clk, .ctl_out_valid, .ctl_out_data, .ctl_out_first, .ctl_out_ready,
		.diag, .diag_valid, .diag_ack);
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Data settles three cycles before the strobe edge
	task automatic rx_byte(input logic [7:0] v);
		ser_rx_data = v;
		step(3);
		ser_rx_valid = 1'b1;
		step(3);
		ser_rx_valid = 1'b0;
	endtask
	task automatic frame_end;
		ser_rx_frame_end = 1'b1;
		step(2);
		ser_rx_frame_end = 1'b0;
		step(2);
	endtask
	task automatic sc_seq;
		repeat (4) ctl_u.send_cmd(1'b0);
		step(10);
		`CHK(diag_valid, 1'b0)
		ctl_u.send_cmd(1'b1);
		step(3);
		`CHK(out_data_error, 1'b1)
		`CHK(in_data_error, 1'b0)
		ctl_u.take_diag(d);
		`CHK(d, 5'h08)
		step(4);
		`CHK(diag_valid, 1'b0)
	endtask
	task automatic sc_out_ovf;
		ser_tx_ready = 1'b0;
		ctl_u.flood(33);
		ctl_u.take_diag(d);
		`CHK(d, 5'h10)
		`CHK(ser_tx_data, 8'h00)
		ser_tx_ready = 1'b1;
		step(40);
		`CHK(ser_tx_valid, 1'b0)
	endtask
	task automatic sc_in_ovf;
		ctl_in_ready = 1'b0;
		for (int i = 0; i < 33; i++) rx_byte(i[7:0]);
		frame_end();
		ctl_u.take_diag(d);
		`CHK(d, 5'h04)
		`CHK(ctl_in_data, 8'h00)
		ctl_in_ready = 1'b1;
		step(40);
		`CHK(ctl_in_valid, 1'b0)
	endtask
	task automatic sc_frame;
		for (int i = 0; i < 506; i++) rx_byte(i[7:0]);
		step(10);
		`CHK(diag_valid, 1'b0)
		rx_byte(8'h5a);
		ctl_u.take_diag(d);
		`CHK(d, 5'h01)
		frame_end();
	endtask
	task automatic sc_lost;
		ser_rx_lost = 1'b1;
		step(1);
		ser_rx_lost = 1'b0;
		step(6);
		`CHK(in_data_error, 1'b1)
		`CHK(out_data_error, 1'b0)
		ctl_u.take_diag(d);
		`CHK(d, 5'h02)
		`CHK(in_data_error, 1'b0)
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		step(16);
		reset = 1'b0;
		sc_seq();
		sc_out_ovf();
		sc_in_ovf();
		sc_frame();
		sc_lost();
		report_and_stop();
	end
endmodule
bind gateway_buffer_diagnostics gbd_props chk_u (.clk, .reset, .ctl_out_valid, .ctl_out_ready,
	.ctl_out_first, .ctl_out_data, .ser_rx_lost, .diag, .diag_valid, .diag_ack, .out_data_error,
	.in_data_error);
